// ### common/hsc_pkg.sv
/*
  hsc_pkg: constants for the holdover and sync configuration register.
  Assumes a single 125 MHz core clock and a 32-bit serial frame.
*/
package hsc_pkg;
  // register geometry
  localparam int unsigned HSC_REG_W = 28;
  localparam int unsigned HSC_ADDR_W = 4;
  localparam int unsigned HSC_FRAME_W = HSC_REG_W + HSC_ADDR_W;
  localparam logic [HSC_ADDR_W-1:0] HSC_REG_ADDR = 4'h9;
  localparam logic [HSC_REG_W-1:0] HSC_REG_RESET = 28'h0000000;
  // field positions
  localparam int unsigned HSC_B_KEEP1 = 0;
  localparam int unsigned HSC_B_KEEP2 = 1;
  localparam int unsigned HSC_B_FREEZE = 2;
  localparam int unsigned HSC_B_TRIG = 3;
  localparam int unsigned HSC_B_REACT = 4;
  localparam int unsigned HSC_B_LOCK_WIN = 6;
  localparam int unsigned HSC_B_POL = 8;
  localparam int unsigned HSC_B_DSYNC = 9;
  localparam int unsigned HSC_B_SBYP = 10;
  localparam int unsigned HSC_B_PRES = 11;
  localparam int unsigned HSC_B_LOCKSKIP = 12;
  localparam int unsigned HSC_B_LOWF = 13;
  localparam int unsigned HSC_B_PRESET = 14;
  localparam int unsigned HSC_B_FBBIAS = 15;
  localparam int unsigned HSC_B_OUTBIAS = 17;
  localparam int unsigned HSC_B_AUXBIAS = 19;
  localparam int unsigned HSC_B_AUXOFF = 20;
  localparam int unsigned HSC_B_SWING = 21;
  localparam int unsigned HSC_B_SIGLO = 24;
  localparam int unsigned HSC_B_SIGHI = 26;
  // reserved bits read as zero
  localparam logic [HSC_REG_W-1:0] HSC_RSVD_MASK = 28'h0c00000;
  // reactivation counts in reference cycles, per two-bit code
  localparam logic [9:0] HSC_REACT_00 = 10'h040;
  localparam logic [9:0] HSC_REACT_01 = 10'h080;
  localparam logic [9:0] HSC_REACT_10 = 10'h100;
  localparam logic [9:0] HSC_REACT_11 = 10'h200;
  // low-frequency gate: a feedback period longer than this stops sync
  localparam int unsigned HSC_CLK_KHZ = 125000;
  localparam int unsigned HSC_LOWF_KHZ = 600;
  localparam int unsigned HSC_LOWF_CYC_INT = HSC_CLK_KHZ / HSC_LOWF_KHZ;
  localparam logic [8:0] HSC_LOWF_CYC = HSC_LOWF_CYC_INT[8:0];
  // keep-1 sequencer
  typedef enum logic [1:0] {HSC_ARMED, HSC_HELD, HSC_WAIT} hsc_keep_type;
endpackage : hsc_pkg

// ### rtl/hsc_serial.sv
/*
  hsc_serial: serial control port frame engine.
  Assumes its inputs are already synchronised to CLK_I; a frame is 32
  bits, MSB first, data in bits 31..4 and address in bits 3..0.
*/
`timescale 1ns/100ps
`default_nettype none
module hsc_serial
  import hsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic le_i,
  input wire logic [HSC_REG_W-1:0] rd_data_i,
  output logic wr_o,
  output logic [HSC_REG_W-1:0] wr_data_o,
  output logic sdo_o
);
  logic sclk_d_r;
  logic le_d_r;
  logic [HSC_FRAME_W-1:0] shift_r;
  logic [HSC_FRAME_W-1:0] out_r;
  logic [5:0] cnt_r;
  logic rise;
  logic fall;
  logic le_rise;
  logic le_fall;

  // edge detection on synchronised levels
  assign rise = sclk_i & ~sclk_d_r;
  assign fall = ~sclk_i & sclk_d_r;
  assign le_rise = le_i & ~le_d_r;
  assign le_fall = ~le_i & le_d_r;
  assign sdo_o = out_r[HSC_FRAME_W-1];

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sclk_d_r <= 1'b0;
      le_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_i;
      le_d_r <= le_i;
    end
  end

  // shift in while latch enable is low; beyond 32 bits the earliest bits shift out
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shift_r <= '0;
      cnt_r <= 6'h00;
    end
    else if (le_fall)
      cnt_r <= 6'h00;
    else if (rise && !le_i)
    begin
      shift_r <= {shift_r[HSC_FRAME_W-2:0], sdi_i};
      if (cnt_r != 6'h20)
        cnt_r <= cnt_r + 6'h01;
    end
  end

  // readback frame loaded at frame start, shifted on falling sclk
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      out_r <= '0;
    else if (le_fall)
      out_r <= {rd_data_i, HSC_REG_ADDR};
    else if (fall && !le_i)
      out_r <= {out_r[HSC_FRAME_W-2:0], 1'b0};
  end

  // a short frame or a foreign address writes nothing
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_o <= 1'b0;
      wr_data_o <= '0;
    end
    else
    begin
      wr_o <= le_rise && cnt_r == 6'h20 &&
              shift_r[HSC_ADDR_W-1:0] == HSC_REG_ADDR;
      wr_data_o <= shift_r[HSC_FRAME_W-1:HSC_ADDR_W];
    end
  end
endmodule : hsc_serial
`default_nettype wire

// ### rtl/hsc_top.sv
/*
  hsc_top: holdover and sync configuration register with its decode.
  Assumes pins arrive asynchronously; nv load, internal strobes and mux
  selects come from logic on CLK_I.
*/
// Contract
// - bit 0 enables keep function one
// - bit 1 enables keep function two
// - bit 2 freezes pump like the pin
// - trigger bit forces freeze, else follows lock
// - keep one rearms after 64..512 ref cycles
// - bits 6,7 are lock window upper bits
// - polarity 0 inverts internal freeze and reset
// - divider sync off only counts in gating mode
// - start bypass skips oscillator start sync
// - presence skip runs sync without clocks
// - lock skip stops waiting for first lock
// - low-frequency gate needs feedback above 600 kHz
// - preset source chooses keep one for preset
// - feedback divider bias cut field
// - output divider bias cut field
// - aux bias bit biases aux negative pin
// - aux off disables buffer, else mux selects
// - bit 21 gives output 9 high swing
// - pin two low selects low signaling field
// - pin two high selects high signaling field
`timescale 1ns/100ps
`default_nettype none
module hsc_top
  import hsc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic SCLK_I,
  input wire logic SDI_I,
  input wire logic LE_I,
  output logic SDO_O,
  input wire logic NV_LOAD_I,
  input wire logic [HSC_REG_W-1:0] NV_DATA_I,
  input wire logic FREEZE_PIN_I,
  input wire logic ANALOG_LOCK_I,
  input wire logic REF_CLK_I,
  input wire logic FB_CLK_I,
  input wire logic CLK_PRESENT_I,
  input wire logic CONFIG_PIN_TWO_I,
  input wire logic HOLD_INT_I,
  input wire logic RESET_INT_I,
  input wire logic START_REQ_I,
  input wire logic FEEDBACK_MUX_SELECT_I,
  input wire logic OUTPUT_MUX_SELECT_I,
  output logic [HSC_REG_W-1:0] REG_VALUE_O,
  output logic FREQ_KEEP_FN1_EN_O,
  output logic FREQ_KEEP_FN2_EN_O,
  output logic PUMP_FREEZE_O,
  output logic KEEP1_ACTIVE_LOW_N_O,
  output logic KEEP1_ARMED_O,
  output logic [1:0] LOCK_WINDOW_EXT_O,
  output logic HOLD_INT_O,
  output logic RESET_INT_O,
  output logic SYNC_ENABLE_O,
  output logic START_TO_DIVIDERS_O,
  output logic START_TO_OSC_O,
  output logic REF_DIVIDER_PRESET_N_O,
  output logic [1:0] FEEDBACK_DIV_BIAS_CUT_O,
  output logic [1:0] OUTPUT_DIV_BIAS_CUT_O,
  output logic AUX_NEG_BIAS_EN_O,
  output logic AUX_BUFFER_EN_O,
  output logic OUT9_HIGH_SWING_O,
  output logic [1:0] OUT9_SIG_SEL_O
);
  localparam int unsigned NSYNC = 9;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] pin_r;
  logic sclk_s, sdi_s, le_s, freeze_pin_s, lock_s;
  logic ref_s, fb_s, present_s, pin_two_s;
  logic [HSC_REG_W-1:0] cfg_r;
  logic host_wr;
  logic [HSC_REG_W-1:0] host_data;
  logic ref_d_r;
  logic ref_tick;
  logic fb_d_r;
  logic fb_tick;
  hsc_keep_type keep_r;
  logic [9:0] react_cnt_r;
  logic [9:0] react_lim;
  logic keep1_cond;
  logic first_lock_r;
  logic [8:0] fb_per_r;
  logic freq_ok_r;
  logic sync_en;
  logic gate_mode_r;
  logic start_d_r;

  // every pin passes two flip-flops; only the second stage is read
  assign pin_raw = {CONFIG_PIN_TWO_I, CLK_PRESENT_I, FB_CLK_I, REF_CLK_I,
                    ANALOG_LOCK_I, FREEZE_PIN_I, LE_I, SDI_I, SCLK_I};
  generate
    for (genvar g = 0; g < NSYNC; g++)
    begin : g_sync
      always_ff @(posedge CLK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
        begin
          meta_r[g] <= (g == 2) ? 1'b1 : 1'b0; // latch enable idles high
          pin_r[g] <= (g == 2) ? 1'b1 : 1'b0;
        end
        else
        begin
          meta_r[g] <= pin_raw[g];
          pin_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate
  assign {pin_two_s, present_s, fb_s, ref_s, lock_s, freeze_pin_s, le_s,
          sdi_s, sclk_s} = pin_r;

  hsc_serial u_serial (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .sclk_i(sclk_s),
    .sdi_i(sdi_s),
    .le_i(le_s),
    .rd_data_i(cfg_r),
    .wr_o(host_wr),
    .wr_data_o(host_data),
    .sdo_o(SDO_O)
  );

  // nv load and host write; host wins a same-cycle collision as newer
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      cfg_r <= HSC_REG_RESET;
    else if (host_wr)
      cfg_r <= host_data & ~HSC_RSVD_MASK;
    else if (NV_LOAD_I)
      cfg_r <= NV_DATA_I & ~HSC_RSVD_MASK;
  end
  assign REG_VALUE_O = cfg_r;

  // plain field decode
  assign FREQ_KEEP_FN1_EN_O = cfg_r[HSC_B_KEEP1];
  assign FREQ_KEEP_FN2_EN_O = cfg_r[HSC_B_KEEP2];
  assign LOCK_WINDOW_EXT_O = cfg_r[HSC_B_LOCK_WIN +: 2];
  assign FEEDBACK_DIV_BIAS_CUT_O = cfg_r[HSC_B_FBBIAS +: 2];
  assign OUTPUT_DIV_BIAS_CUT_O = cfg_r[HSC_B_OUTBIAS +: 2];
  assign AUX_NEG_BIAS_EN_O = cfg_r[HSC_B_AUXBIAS];
  assign OUT9_HIGH_SWING_O = cfg_r[HSC_B_SWING];

  // aux buffer: off bit overrides, else either mux select wakes it
  assign AUX_BUFFER_EN_O = !cfg_r[HSC_B_AUXOFF] &&
    (FEEDBACK_MUX_SELECT_I || OUTPUT_MUX_SELECT_I);

  // output 9 signaling follows the pin-two field live
  assign OUT9_SIG_SEL_O = pin_two_s ? cfg_r[HSC_B_SIGHI +: 2]
                                    : cfg_r[HSC_B_SIGLO +: 2];

  // internal freeze and reset: polarity 0 means inverted
  assign HOLD_INT_O = HOLD_INT_I ^ ~cfg_r[HSC_B_POL];
  assign RESET_INT_O = RESET_INT_I ^ ~cfg_r[HSC_B_POL];

  // keep-1 trigger: test setting forces it, else analog lock drives it
  assign keep1_cond = cfg_r[HSC_B_KEEP1] &&
    (cfg_r[HSC_B_TRIG] || lock_s);

  // reference cycle ticks for the rearm count
  assign ref_tick = ref_s & ~ref_d_r;
  assign fb_tick = fb_s & ~fb_d_r;
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      ref_d_r <= 1'b0;
      fb_d_r <= 1'b0;
    end
    else
    begin
      ref_d_r <= ref_s;
      fb_d_r <= fb_s;
    end
  end

  // rearm count chosen by the two-bit field
  always_comb
  begin
    case (cfg_r[HSC_B_REACT +: 2])
      2'b00: react_lim = HSC_REACT_00;
      2'b01: react_lim = HSC_REACT_01;
      2'b10: react_lim = HSC_REACT_10;
      default: react_lim = HSC_REACT_11;
    endcase
  end

  // keep-1 sequencer: held, then a dead time before it may trigger again
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      keep_r <= HSC_ARMED;
      react_cnt_r <= 10'h000;
    end
    else
    begin
      case (keep_r)
        HSC_ARMED:
        begin
          react_cnt_r <= 10'h000;
          if (keep1_cond)
            keep_r <= HSC_HELD;
        end
        HSC_HELD:
          if (!keep1_cond)
            keep_r <= HSC_WAIT;
        HSC_WAIT:
          if (!cfg_r[HSC_B_KEEP1])
            keep_r <= HSC_ARMED;
          else if (cfg_r[HSC_B_TRIG])
          begin
            // test setting must not sit out a dead time
            keep_r <= HSC_HELD;
            react_cnt_r <= 10'h000;
          end
          else if (ref_tick)
          begin
            if (react_cnt_r == react_lim - 10'h001)
              keep_r <= HSC_ARMED;
            react_cnt_r <= react_cnt_r + 10'h001;
          end
        default:
          keep_r <= HSC_ARMED;
      endcase
    end
  end
  assign KEEP1_ACTIVE_LOW_N_O = (keep_r != HSC_HELD);
  assign KEEP1_ARMED_O = (keep_r == HSC_ARMED);

  // pump tri-state: register bit, pin, or held keep-1 function
  assign PUMP_FREEZE_O = cfg_r[HSC_B_FREEZE] || freeze_pin_s ||
                         (keep_r == HSC_HELD);

  // m divider preset from keep-1 unless the source bit disconnects it
  assign REF_DIVIDER_PRESET_N_O = cfg_r[HSC_B_PRESET] ||
                                  KEEP1_ACTIVE_LOW_N_O;

  // first lock is sticky; lock may rise in the cycle a write lands
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      first_lock_r <= 1'b0;
    else if (lock_s)
      first_lock_r <= 1'b1;
  end

  // feedback frequency check by period; a stopped clock saturates
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      fb_per_r <= 9'h000;
      freq_ok_r <= 1'b0;
    end
    else if (fb_tick)
    begin
      freq_ok_r <= (fb_per_r < HSC_LOWF_CYC);
      fb_per_r <= 9'h000;
    end
    else if (fb_per_r != HSC_LOWF_CYC)
      fb_per_r <= fb_per_r + 9'h001;
    else
      freq_ok_r <= 1'b0;
  end

  // sync gating combines presence, first lock and frequency
  assign sync_en = (cfg_r[HSC_B_PRES] || present_s) &&
                   (cfg_r[HSC_B_LOCKSKIP] || first_lock_r) &&
                   (!cfg_r[HSC_B_LOWF] || freq_ok_r);
  assign SYNC_ENABLE_O = sync_en;

  // gating mode latched from pin two on each nv load, like a strap
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      gate_mode_r <= 1'b0;
    else if (NV_LOAD_I)
      gate_mode_r <= pin_two_s;
  end

  // start path: each stage either re-times by one clock or passes
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      start_d_r <= 1'b0;
    else
      start_d_r <= START_REQ_I && sync_en;
  end
  assign START_TO_OSC_O = cfg_r[HSC_B_SBYP] ? (START_REQ_I && sync_en)
                                            : start_d_r;
  assign START_TO_DIVIDERS_O =
    (gate_mode_r && cfg_r[HSC_B_DSYNC]) ? START_TO_OSC_O
                                        : start_d_r;

  // checks next to the logic they guard
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_host_write_lands:
    assert property (host_wr |=> cfg_r == ($past(host_data) & ~HSC_RSVD_MASK))
    else $error("host write did not land");
  a_rsvd_reads_zero:
    assert property ((cfg_r & HSC_RSVD_MASK) == 28'h0000000)
    else $error("reserved bits not zero");
  a_forced_freeze:
    assert property (cfg_r[HSC_B_KEEP1] && cfg_r[HSC_B_TRIG]
                     ##1 cfg_r[HSC_B_KEEP1] && cfg_r[HSC_B_TRIG]
                     |-> PUMP_FREEZE_O)
    else $error("forced freeze not active");
  a_freeze_bit:
    assert property (cfg_r[HSC_B_FREEZE] |-> PUMP_FREEZE_O)
    else $error("freeze bit ignored");
  a_rearm_dead_time:
    assert property ($rose(keep_r == HSC_WAIT) && cfg_r[HSC_B_KEEP1] &&
                     cfg_r[HSC_B_REACT +: 2] == 2'b00
                     |=> (keep_r != HSC_ARMED) [*8])
    else $error("keep one rearmed too early");
  a_rearm_on_count:
    assert property (keep_r == HSC_WAIT && ref_tick &&
                     react_cnt_r == react_lim - 10'h001
                     |=> keep_r == HSC_ARMED)
    else $error("keep one not rearmed");
  a_polarity_invert:
    assert property (!cfg_r[HSC_B_POL] |-> HOLD_INT_O == !HOLD_INT_I &&
                     RESET_INT_O == !RESET_INT_I)
    else $error("internal lines not inverted");
  a_lock_wait:
    assert property (!cfg_r[HSC_B_LOCKSKIP] && !first_lock_r |-> !sync_en)
    else $error("sync ran before first lock");
  a_low_freq_stop:
    assert property (cfg_r[HSC_B_LOWF] && fb_per_r == HSC_LOWF_CYC
                     ##1 cfg_r[HSC_B_LOWF] && !fb_tick |-> !sync_en)
    else $error("sync ran below frequency gate");
  a_preset_source:
    assert property (!cfg_r[HSC_B_PRESET] && keep_r == HSC_HELD
                     |-> !REF_DIVIDER_PRESET_N_O)
    else $error("preset not driven by keep one");
  a_sig_select:
    assert property (!pin_two_s |-> OUT9_SIG_SEL_O == cfg_r[25:24])
    else $error("wrong low signaling field");
  a_aux_off:
    assert property (cfg_r[HSC_B_AUXOFF] |-> !AUX_BUFFER_EN_O)
    else $error("aux buffer not disabled");
  a_start_sync_delay:
    assert property (!cfg_r[HSC_B_SBYP] && START_REQ_I && sync_en
                     |=> START_TO_OSC_O)
    else $error("start not re-timed");
endmodule : hsc_top
`default_nettype wire

// ### tb/hsc_host.sv
/*
  hsc_host: serial host model that shifts frames in and readback out.
  Assumes a free-running core clock; each link clock level lasts 4 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module hsc_host
(
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic sdi_o,
  output logic le_n_o
);
  // link clock stands still low outside frames
  initial
  begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    le_n_o = 1'b1;
  end

  // msb first; readback is caught just before each rising edge
  task automatic frame(input logic [31:0] f, input int nbits,
    input bit raw, output logic [31:0] rd);
    rd = 32'h0;
    if (!raw)
      f[27:26] = 2'h0;
    @(negedge clk_i);
    le_n_o = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      sdi_o = f[31-i];
      repeat (4) @(negedge clk_i);
      rd = {rd[30:0], sdo_i};
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    le_n_o = 1'b1;
    // data line no longer valid: show the inverse, not the last bit
    sdi_o = ~sdi_o;
  endtask : frame
endmodule : hsc_host
`default_nettype wire

// ### tb/tb_top.sv
/*
  tb_top: self-checking bench for hsc_top against a register model.
  Assumes the serial host model in hsc_host and a 125 MHz core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import hsc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, sclk, sdi, le_n, sdo, nv_load = 1'b0;
  logic [27:0] nv_data = 28'h0, model, reg_value, v;
  logic freeze_pin = 1'b0, lock = 1'b0, ref_clk = 1'b0, fb_clk = 1'b0;
  logic present = 1'b0, pin2 = 1'b0, hold_int = 1'b0, reset_int = 1'b0;
  logic start_req = 1'b0, fbmux = 1'b0, outmux = 1'b0, fb_run = 1'b0;
  logic keep1_en, keep2_en, pump, keep1_n, armed, hold_o, rst_o, sync_en;
  logic start_div, start_osc, preset_n, auxbias, auxbuf, swing, o0, byp;
  logic [1:0] lock_window_ext, fbbias, outbias, sigsel;
  logic [2:0] fb_div = 3'h0;
  logic [6:0] syn_tab [0:6] = '{7'h61, 7'h20, 7'h29, 7'h73, 7'h70,
    7'h40, 7'h45};
  int err_count = 0, checked = 0, cycles = 0, seed = 78, r;

  always #4 clk = ~clk;

  hsc_host hsc_host_i (.clk_i(clk), .sdo_i(sdo), .sclk_o(sclk),
    .sdi_o(sdi), .le_n_o(le_n));

  hsc_top hsc_top_i (.CLK_I(clk), .RESET_N_I(rst_n), .SCLK_I(sclk),
    .SDI_I(sdi), .LE_I(le_n), .SDO_O(sdo), .NV_LOAD_I(nv_load),
    .NV_DATA_I(nv_data), .FREEZE_PIN_I(freeze_pin), .ANALOG_LOCK_I(lock),
    .REF_CLK_I(ref_clk), .FB_CLK_I(fb_clk), .CLK_PRESENT_I(present),
    .CONFIG_PIN_TWO_I(pin2), .HOLD_INT_I(hold_int),
    .RESET_INT_I(reset_int), .START_REQ_I(start_req),
    .FEEDBACK_MUX_SELECT_I(fbmux), .OUTPUT_MUX_SELECT_I(outmux),
    .REG_VALUE_O(reg_value), .FREQ_KEEP_FN1_EN_O(keep1_en),
    .FREQ_KEEP_FN2_EN_O(keep2_en), .PUMP_FREEZE_O(pump),
    .KEEP1_ACTIVE_LOW_N_O(keep1_n), .KEEP1_ARMED_O(armed),
    .LOCK_WINDOW_EXT_O(lock_window_ext), .HOLD_INT_O(hold_o), .RESET_INT_O(rst_o),
    .SYNC_ENABLE_O(sync_en), .START_TO_DIVIDERS_O(start_div),
    .START_TO_OSC_O(start_osc), .REF_DIVIDER_PRESET_N_O(preset_n),
    .FEEDBACK_DIV_BIAS_CUT_O(fbbias), .OUTPUT_DIV_BIAS_CUT_O(outbias),
    .AUX_NEG_BIAS_EN_O(auxbias), .AUX_BUFFER_EN_O(auxbuf),
    .OUT9_HIGH_SWING_O(swing), .OUT9_SIG_SEL_O(sigsel));

  // feedback clock, 8 core cycles a period, well above the gate limit
  always @(negedge clk)
  begin
    fb_div <= fb_div + 3'h1;
    if (fb_run)
      fb_clk <= fb_div[2];
  end

  // hang guard: the whole run needs well under 60000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: value %h, want %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask : chk_bit

  // nv load; reserved bits are expected to come out as zero
  task automatic nv(input logic [27:0] d);
    @(negedge clk);
    nv_data = d;
    nv_load = 1'b1;
    @(negedge clk);
    nv_load = 1'b0;
    model = d & ~HSC_RSVD_MASK;
    repeat (4) @(negedge clk);
  endtask : nv

  // host frame; only a full frame to our address changes the model
  task automatic wr(input logic [27:0] d, input logic [3:0] a, input int n,
    input bit raw);
    logic [31:0] rd;
    hsc_host_i.frame({d, a}, n, raw, rd);
    if (n == 32)
      chk_val(rd, {model, HSC_REG_ADDR});
    if (n == 32 && a == HSC_REG_ADDR)
      model = (raw ? d : {d[27:24], 2'h0, d[21:0]}) & ~HSC_RSVD_MASK;
    repeat (8) @(negedge clk);
    chk_val(32'(reg_value), 32'(model));
  endtask : wr

  task automatic ref_pulses(input int n);
    repeat (n)
    begin
      ref_clk = 1'b1;
      repeat (3) @(negedge clk);
      ref_clk = 1'b0;
      repeat (3) @(negedge clk);
    end
    repeat (6) @(negedge clk);
  endtask : ref_pulses

  // field decode, with keep-1 idle so the freeze shows bit 2 only
  task automatic chk_dec();
    chk_bit(keep1_en, model[0]);
    chk_bit(keep2_en, model[1]);
    chk_bit(pump, model[2]);
    chk_val(32'(lock_window_ext), 32'(model[7:6]));
    chk_bit(hold_o, model[8] ? hold_int : !hold_int);
    chk_bit(rst_o, model[8] ? reset_int : !reset_int);
    chk_val(32'(fbbias), 32'(model[16:15]));
    chk_val(32'(outbias), 32'(model[18:17]));
    chk_bit(auxbias, model[19]);
    chk_bit(auxbuf, !model[20] & (fbmux | outmux));
    chk_bit(swing, model[21]);
    chk_val(32'(sigsel), 32'(pin2 ? model[27:26] : model[25:24]));
    chk_val(32'(reg_value), 32'(model));
  endtask : chk_dec

  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    model = HSC_REG_RESET;
    chk_val(32'(reg_value), 32'(model));
    chk_bit(armed, 1'b1);
    chk_bit(preset_n, 1'b1);
    // sync gate table; lock stays low until the last entry
    for (int i = 0; i < 7; i++)
    begin
      present = syn_tab[i][3];
      lock = syn_tab[i][2];
      fb_run = syn_tab[i][1];
      nv({14'h0, syn_tab[i][4], syn_tab[i][5], syn_tab[i][6], 11'h0});
      repeat (260) @(negedge clk);
      chk_bit(sync_en, syn_tab[i][0]);
    end
    lock = 1'b0;
    // start paths; both re-timed stages share one register of delay
    for (int j = 0; j < 8; j++)
    begin
      pin2 = j[2];
      repeat (4) @(negedge clk);
      nv({14'h0, 3'h3, j[0], j[1], 9'h0});
      start_req = 1'b1;
      repeat (4) @(negedge clk);
      chk_bit(start_osc, 1'b1);
      start_req = 1'b0;
      #1;
      o0 = !j[0];
      byp = j[2] & j[1];
      chk_bit(start_osc, o0);
      chk_bit(start_div, byp ? o0 : 1'b1);
      @(negedge clk);
      chk_bit(start_osc, 1'b0);
      chk_bit(start_div, 1'b0);
    end
    // random contents through both load paths, pins shuffled
    for (int i = 0; i < 12; i++)
    begin
      v = 28'($random(seed));
      v[0] = 1'b0;
      r = $random(seed);
      {pin2, hold_int, reset_int, fbmux, outmux} = r[4:0];
      if (i[0])
        wr(v, HSC_REG_ADDR, 32, i[1]);
      else
        nv(v);
      chk_dec();
    end
    // refused frames: wrong address, then one bit short
    wr(28'($random(seed)), 4'h8, 32, 1'b1);
    wr(28'($random(seed)), HSC_REG_ADDR, 31, 1'b1);
    // keep-1 dead time for each count code
    for (int c = 0; c < 4; c++)
    begin
      nv({13'h0, c[0], 8'h0, c[1:0], 4'h1});
      chk_bit(keep1_en, 1'b1);
      lock = 1'b1;
      repeat (6) @(negedge clk);
      chk_bit(keep1_n, 1'b0);
      chk_bit(pump, 1'b1);
      chk_bit(preset_n, c[0]);
      lock = 1'b0;
      // the hold must end first, or the first reference edge is lost
      repeat (4) @(negedge clk);
      chk_bit(pump, 1'b0);
      ref_pulses((64 << c) - 1);
      chk_bit(armed, 1'b0);
      ref_pulses(1);
      chk_bit(armed, 1'b1);
      chk_bit(preset_n, 1'b1);
    end
    nv(28'h9);
    chk_bit(pump, 1'b1);
    nv(28'h0);
    chk_bit(armed, 1'b1);
    freeze_pin = 1'b1;
    repeat (4) @(negedge clk);
    chk_bit(pump, 1'b1);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
